// File: rtl/fmsc_bank.v
// Status and control register bank of the fieldbus master, Avalon-MM slave.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "fmsc_defs.vh"
module fmsc_bank (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Avalon-MM register slave
    input  wire [5:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    input  wire [3:0]   avs_byteenable,
    output reg  [31:0]  avs_readdata,
    output wire         avs_waitrequest,
    // Module condition from the firmware side
    input  wire         init_done,
    input  wire         cfg_loaded,
    input  wire         net_connected,
    input  wire         role_primary,
    input  wire         partner_present,
    input  wire         net_error,
    input  wire         slave_fault,
    input  wire         slave_error,
    input  wire [126:0] node_diag_waiting,
    input  wire [126:0] node_configured,
    input  wire [31:0]  module_net_address,
    // Ethernet service conditions
    input  wire         ring_ok,
    input  wire         time_sync_ok,
    input  wire         net_mgmt_ok,
    input  wire         file_fetch_fail,
    input  wire         upgrade_refused,
    input  wire         web_page_missing,
    input  wire         event_log_disrupted,
    // Outcomes toward the fieldbus engine
    output reg  [7:0]   network_state_code,
    output reg  [126:0] node_exchange_permit,
    output wire         hot_standby_active,
    // Interrupt
    output wire         irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [3:0]   ctrl_q;
    reg  [127:0] ena_q;
    reg  [3:0]   irq_stat_q;
    reg  [3:0]   irq_mask_q;
    reg  [3:0]   irq_stat_d;
    reg  [126:0] diag_q;
    reg  [7:0]   op_state_q;
    reg  [7:0]   red_role_q;
    reg  [7:0]   health_q;
    reg  [7:0]   eth_q;
    reg  [31:0]  addr_q;
    reg          ack_q;
    reg  [7:0]   ns_d;
    reg  [7:0]   op_d;
    reg  [7:0]   red_d;
    reg  [7:0]   nh_d;
    reg  [7:0]   eth_d;
    reg  [31:0]  rd_d;
    reg  [3:0]   events;
    wire         req;
    wire         wr_go;
    wire [31:0]  bmask;

    assign req   = avs_read | avs_write;
    assign wr_go = avs_write & ack_q;
    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Every access waits exactly one cycle, so read data is registered.
    // The first edge of a request captures the read word and sets the
    // acknowledge; the second edge completes it and lets a write land.
    // A master that holds its request keeps seeing one wait per access.
    assign avs_waitrequest = req & ~ack_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q) begin
                avs_readdata <= rd_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Network state selection
    // ------------------------------------------------------------------
    // Priority order makes a multi-bit request harmless, though the
    // host is still expected to set one bit at a time.
    // code four unused
    // No branch below yields code four, so that value never appears.
    always @* begin
        if (!init_done) begin
            ns_d = `FMSC_NS_IDLE;
        end else if (!cfg_loaded) begin
            ns_d = `FMSC_NS_NOCFG;
        end else if (ctrl_q[`FMSC_CTRL_STOP]) begin
            ns_d = `FMSC_NS_STOP;
        end else if (ctrl_q[`FMSC_CTRL_RUN]) begin
            ns_d = `FMSC_NS_OPERATE;
        end else if (ctrl_q[`FMSC_CTRL_CLEAR]) begin
            ns_d = `FMSC_NS_CLEAR;
        end else begin
            ns_d = `FMSC_NS_OFFLINE;
        end
    end

    // ------------------------------------------------------------------
    // Operating state, role and health codes
    // ------------------------------------------------------------------
    always @* begin
        // operating state code
        // A connected network that sits offline reports the unconnected
        // code, since no connected code exists for that state.
        if (!init_done) begin
            op_d = `FMSC_OP_INIT;
        end else if (!cfg_loaded) begin
            op_d = `FMSC_OP_UNCFG;
        end else if (!net_connected) begin
            op_d = `FMSC_OP_UNCONN;
        end else begin
            case (ns_d)
                `FMSC_NS_STOP:    op_d = `FMSC_OP_STOP;
                `FMSC_NS_OPERATE: op_d = `FMSC_OP_RUN;
                `FMSC_NS_CLEAR:   op_d = `FMSC_OP_CLEAR;
                default:          op_d = `FMSC_OP_UNCONN;
            endcase
        end
        if (!ctrl_q[`FMSC_CTRL_HOT_STANDBY]) begin
            red_d = `FMSC_RED_ALONE;
        end else if (role_primary) begin
            red_d = partner_present ? `FMSC_RED_PRI_SB : `FMSC_RED_PRI;
        end else begin
            red_d = partner_present ? `FMSC_RED_SB_PRI : `FMSC_RED_SB;
        end
        if (net_error) begin
            nh_d = `FMSC_NH_NETERR;
        end else if (slave_fault && slave_error) begin
            nh_d = `FMSC_NH_BOTH;
        end else if (slave_fault) begin
            nh_d = `FMSC_NH_FAULT;
        end else if (slave_error) begin
            nh_d = `FMSC_NH_ERROR;
        end else begin
            nh_d = `FMSC_NH_IDLE;
        end
        // one bit per service, reserved bit low
        eth_d = {~event_log_disrupted, ~web_page_missing, ~upgrade_refused,
                 ~file_fetch_fail, net_mgmt_ok, 1'b0, time_sync_ok,
                 ring_ok};
    end

    // ------------------------------------------------------------------
    // Status capture and event detection
    // ------------------------------------------------------------------
    // Status words are held in flops so a bus read never sees them move
    // in the middle of the cycle that returns them.
    // re-evaluated every cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            diag_q             <= {127{1'b0}};
            op_state_q         <= `FMSC_OP_INIT;
            red_role_q         <= `FMSC_RED_ALONE;
            network_state_code <= `FMSC_NS_IDLE;
            health_q           <= `FMSC_NH_IDLE;
            eth_q              <= `FMSC_RST_ETH;
            addr_q             <= 32'h0000_0000;
        end else begin
            diag_q             <= node_diag_waiting;
            op_state_q         <= op_d;
            red_role_q         <= red_d;
            network_state_code <= ns_d;
            health_q           <= nh_d;
            eth_q              <= eth_d;
            addr_q             <= module_net_address;
        end
    end

    // Events compare the freshly computed codes against the held ones.
    // A diagnostics bit rising, a service bit falling or any change of the
    // network state or health code counts, so a health fault that clears again raises a second interrupt.
    always @* begin
        events = 4'h0;
        events[`FMSC_IRQ_DIAG]   = |(node_diag_waiting & ~diag_q);
        events[`FMSC_IRQ_NSTATE] = (ns_d != network_state_code);
        events[`FMSC_IRQ_HEALTH] = (nh_d != health_q);
        events[`FMSC_IRQ_ETH]    = |(eth_q & ~eth_d);
    end

    // ------------------------------------------------------------------
    // Node exchange permission
    // ------------------------------------------------------------------
    // The permit is registered so the fieldbus engine sees one clean
    // level per cycle, at the cost of one cycle of lag.
    // enable gates exchange
    genvar n;
    generate
        for (n = 0; n < `FMSC_NODES; n = n + 1) begin : g_node
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    node_exchange_permit[n] <= 1'b0;
                end else begin
                    node_exchange_permit[n] <= ena_q[n] & node_configured[n];
                end
            end
        end
    endgenerate

    assign hot_standby_active = ctrl_q[`FMSC_CTRL_HOT_STANDBY];

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // A new event beats a write-one-to-clear in the same cycle.
    // Losing an event to a clear would hide it from software for good.
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_go && avs_address == `FMSC_OFF_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~(avs_writedata[3:0] & bmask[3:0]);
        end
        irq_stat_d = irq_stat_d | events;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q     <= `FMSC_RST_CTRL;
            ena_q      <= {128{1'b0}};
            irq_stat_q <= `FMSC_RST_IRQ;
            irq_mask_q <= `FMSC_RST_IRQ;
        end else begin
            irq_stat_q <= irq_stat_d;
            // Writes land on the completing edge, merged per byte lane.
            if (wr_go) begin
                case (avs_address)
                    `FMSC_OFF_CTRL: begin
                        ctrl_q <= (ctrl_q & ~bmask[3:0])
                                | (avs_writedata[3:0] & bmask[3:0]);
                    end
                    `FMSC_OFF_IRQ_MASK: begin
                        irq_mask_q <= (irq_mask_q & ~bmask[3:0])
                                    | (avs_writedata[3:0] & bmask[3:0]);
                    end
                    `FMSC_OFF_ENA0: begin
                        ena_q[31:0] <= (ena_q[31:0] & ~bmask)
                                     | (avs_writedata & bmask);
                    end
                    `FMSC_OFF_ENA0 + 6'h01: begin
                        ena_q[63:32] <= (ena_q[63:32] & ~bmask)
                                      | (avs_writedata & bmask);
                    end
                    `FMSC_OFF_ENA0 + 6'h02: begin
                        ena_q[95:64] <= (ena_q[95:64] & ~bmask)
                                      | (avs_writedata & bmask);
                    end
                    `FMSC_OFF_ENA0 + 6'h03: begin
                        // Bit 127 has no node and stays zero.
                        ena_q[127:96] <= ((ena_q[127:96] & ~bmask)
                                       | (avs_writedata & bmask))
                                       & 32'h7FFF_FFFF;
                    end
                    default: begin
                        ctrl_q <= ctrl_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero and ignore writes.
    // Bit 127 of each vector has no node behind it and reads as zero.
    always @* begin
        case (avs_address)
            `FMSC_OFF_STATE:
                rd_d = {health_q, network_state_code, red_role_q, op_state_q};
            `FMSC_OFF_ETH:          rd_d = {24'h000000, eth_q};
            `FMSC_OFF_ADDR:         rd_d = addr_q;
            `FMSC_OFF_CTRL:         rd_d = {28'h0000000, ctrl_q};
            `FMSC_OFF_DIAG0:        rd_d = diag_q[31:0];
            `FMSC_OFF_DIAG0 + 6'h01: rd_d = diag_q[63:32];
            `FMSC_OFF_DIAG0 + 6'h02: rd_d = diag_q[95:64];
            `FMSC_OFF_DIAG0 + 6'h03: rd_d = {1'b0, diag_q[126:96]};
            `FMSC_OFF_ENA0:         rd_d = ena_q[31:0];
            `FMSC_OFF_ENA0 + 6'h01: rd_d = ena_q[63:32];
            `FMSC_OFF_ENA0 + 6'h02: rd_d = ena_q[95:64];
            `FMSC_OFF_ENA0 + 6'h03: rd_d = ena_q[127:96];
            `FMSC_OFF_IRQ_STAT:     rd_d = {28'h0000000, irq_stat_q};
            `FMSC_OFF_IRQ_MASK:     rd_d = {28'h0000000, irq_mask_q};
            default:                rd_d = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // The level stays high until software clears every unmasked bit.
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule // fmsc_bank

// File: rtl/fmsc_defs.vh
// Register offsets, field positions, codes and reset values of the bank.
`ifndef FMSC_DEFS_VH
`define FMSC_DEFS_VH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define FMSC_OFF_STATE      6'h00
`define FMSC_OFF_ETH        6'h01
`define FMSC_OFF_ADDR       6'h02
`define FMSC_OFF_CTRL       6'h03
`define FMSC_OFF_DIAG0      6'h04
`define FMSC_OFF_ENA0       6'h08
`define FMSC_OFF_IRQ_STAT   6'h0C
`define FMSC_OFF_IRQ_MASK   6'h0D

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FMSC_CTRL_STOP      0
`define FMSC_CTRL_RUN       1
`define FMSC_CTRL_CLEAR     2
`define FMSC_CTRL_HOT_STANDBY      3
`define FMSC_ETH_RSVD       2
`define FMSC_IRQ_DIAG       0
`define FMSC_IRQ_NSTATE     1
`define FMSC_IRQ_HEALTH     2
`define FMSC_IRQ_ETH        3

// ----------------------------------------------------------------------
// Module operating state codes
// ----------------------------------------------------------------------
`define FMSC_OP_INIT        8'h00
`define FMSC_OP_UNCFG       8'h01
`define FMSC_OP_UNCONN      8'h02
`define FMSC_OP_STOP        8'h03
`define FMSC_OP_RUN         8'h04
`define FMSC_OP_CLEAR       8'h05

// ----------------------------------------------------------------------
// Redundancy role codes
// ----------------------------------------------------------------------
`define FMSC_RED_ALONE      8'h01
`define FMSC_RED_PRI        8'h02
`define FMSC_RED_PRI_SB     8'h03
`define FMSC_RED_SB         8'h04
`define FMSC_RED_SB_PRI     8'h05

// ----------------------------------------------------------------------
// Network state codes
// ----------------------------------------------------------------------
`define FMSC_NS_IDLE        8'h00
`define FMSC_NS_NOCFG       8'h01
`define FMSC_NS_OFFLINE     8'h02
`define FMSC_NS_STOP        8'h03
`define FMSC_NS_OPERATE     8'h05
`define FMSC_NS_CLEAR       8'h06

// ----------------------------------------------------------------------
// Network health codes
// ----------------------------------------------------------------------
`define FMSC_NH_IDLE        8'h00
`define FMSC_NH_NETERR      8'h01
`define FMSC_NH_FAULT       8'h02
`define FMSC_NH_ERROR       8'h03
`define FMSC_NH_BOTH        8'h04

// ----------------------------------------------------------------------
// Reset values and node count
// ----------------------------------------------------------------------
`define FMSC_RST_CTRL       4'h0
`define FMSC_RST_IRQ        4'h0
`define FMSC_RST_ETH        8'hFB
`define FMSC_NODES          127

`endif

// File: test/fmsc_host.sv
// Host controller model issuing register accesses over Avalon-MM.
`timescale 1ns/1ns
module fmsc_host (
    // Clock and slave answer
    input  wire         clk,
    input  wire         avs_waitrequest,
    // Master request
    output logic [5:0]  avs_address,
    output logic        avs_read,
    output logic        avs_write,
    output logic [31:0] avs_writedata,
    // Wait limit used up
    output logic        tmo
);
    // Expected read words, oldest first.
    logic [31:0] exp_q[$];
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        tmo = 1'b0;
    end
    // one access at a time, address, direction and data word as the host sets them.
    task xfer(input logic [5:0] a, input logic we, input logic [31:0] d);
        integer i;
        begin
            // Request rises just after an edge and holds until answered.
            @(posedge clk);
            avs_address <= a;
            avs_write <= we;
            avs_read <= !we;
            avs_writedata <= d;
            i = 0;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0 && i < 50) begin
                @(posedge clk);
                i = i + 1;
            end
            // Released at the very edge that sampled waitrequest low.
            tmo <= (i == 50);
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            // Stale data is not left on the bus once released.
            avs_writedata <= ~d;
        end
    endtask
endmodule // fmsc_host

// File: test/fmsc_props.sv
// Port checker of the fieldbus master status and control bank.
`timescale 1ns/1ns
`include "fmsc_defs.vh"
module fmsc_props (
    // Clock, reset and register bus
    input wire         clk,
    input wire         rst,
    input wire [5:0]   avs_address,
    input wire         avs_read,
    input wire         avs_write,
    input wire [31:0]  avs_writedata,
    input wire [3:0]   avs_byteenable,
    input wire         avs_waitrequest,
    // Firmware conditions and outcomes
    input wire         init_done,
    input wire         cfg_loaded,
    input wire [126:0] node_configured,
    input wire [7:0]   network_state_code,
    input wire [126:0] node_exchange_permit,
    input wire         hot_standby_active,
    input wire         irq
);
    reg  [3:0] ctrl_q;
    reg        ena0_q;
    reg  [3:0] mask_q;
    wire       wr_done;
    wire       rdy;
    wire       permit0_src;
    assign permit0_src = ena0_q && node_configured[0];
    // Lane 0 writes only; the bench never narrows byteenable anyway.
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rdy     = init_done && cfg_loaded;
    // Shadow copies of the control word, node 0 enable and mask.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 4'h0;
            ena0_q <= 1'b0;
            mask_q <= 4'h0;
        end else if (wr_done) begin
            if (avs_address == `FMSC_OFF_CTRL) ctrl_q <= avs_writedata[3:0];
            if (avs_address == `FMSC_OFF_ENA0) ena0_q <= avs_writedata[0];
            if (avs_address == `FMSC_OFF_IRQ_MASK) mask_q <= avs_writedata[3:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait longer than one cycle");
    a_wait_idle: assert property (!(avs_read || avs_write)
        |-> !avs_waitrequest) else $error("wait without a request");
    a_net_stop: assert property ((rdy && ctrl_q[0]) [*3]
        |-> network_state_code == `FMSC_NS_STOP) else $error("no stop");
    a_net_run: assert property ((rdy && ctrl_q[1:0] == 2'h2) [*3]
        |-> network_state_code == `FMSC_NS_OPERATE) else $error("no run");
    a_net_clear: assert property ((rdy && ctrl_q[2:0] == 3'h4) [*3]
        |-> network_state_code == `FMSC_NS_CLEAR) else $error("no clear");
    a_net_offline: assert property ((rdy && ctrl_q[2:0] == 3'h0) [*3]
        |-> network_state_code == `FMSC_NS_OFFLINE) else $error("no offline");
    a_code_four: assert property (network_state_code != 8'h04)
        else $error("state code four seen");
    a_standby_follow: assert property (hot_standby_active == ctrl_q[3])
        else $error("standby enable mismatch");
    a_permit_node: assert property (1'b1 |=> node_exchange_permit[0] ==
        $past(permit0_src)) else $error("permit wrong");
    a_irq_masked: assert property (mask_q == 4'h0 |-> !irq)
        else $error("irq while all masked");
    c_stop: cover property (network_state_code == `FMSC_NS_STOP);
    c_irq: cover property (irq);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule // fmsc_props
bind fmsc_bank fmsc_props chk_u (.*);

// File: test/tb_fieldbus_master_status_control.sv
// Self-checking bench of the fieldbus master status and control bank.
`timescale 1ns/1ns
`include "fmsc_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_fieldbus_master_status_control;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire [5:0] avs_address;
    wire avs_read, avs_write, avs_waitrequest, host_tmo;
    wire [31:0] avs_writedata, avs_readdata;
    wire [3:0] avs_byteenable = 4'hF;
    logic init_done, cfg_loaded, net_connected, role_primary;
    logic partner_present, net_error, slave_fault, slave_error;
    logic ring_ok, time_sync_ok, net_mgmt_ok, file_fetch_fail;
    logic upgrade_refused, web_page_missing, event_log_disrupted;
    logic [126:0] node_diag_waiting, node_configured;
    logic [31:0] module_net_address;
    wire [7:0] network_state_code;
    wire [126:0] node_exchange_permit;
    wire hot_standby_active, irq;
    int n_fail = 0;
    int samples_checked = 0;
    logic [31:0] r, e, ew;
    logic [127:0] dv, ev, cv;
    logic [5:0] k;
    fmsc_bank dut_u (.*);
    fmsc_host host_u (.clk, .avs_waitrequest, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .tmo(host_tmo));
    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;
    task conclude;
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] x);
        host_u.exp_q.push_back(x);
        host_u.xfer(a, 1'b0, 32'h0);
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        host_u.xfer(a, 1'b1, d);
    endtask
    // Lets one-cycle status lags land, then stops between edges.
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // Word 0 worked out from the inputs with the chosen priorities.
    function automatic [31:0] w0(input logic [3:0] c);
        logic [7:0] ns, op, ro, he;
        ns = !init_done ? 8'h00 : !cfg_loaded ? 8'h01 : c[0] ? 8'h03 :
             c[1] ? 8'h05 : c[2] ? 8'h06 : 8'h02;
        op = ns < 8'h02 ? ns : (!net_connected || ns == 8'h02) ? 8'h02 :
             ns == 8'h03 ? 8'h03 : ns == 8'h05 ? 8'h04 : 8'h05;
        ro = !c[3] ? 8'h01 : {5'h0, !role_primary, role_primary,
             partner_present};
        he = net_error ? 8'h01 : (slave_fault && slave_error) ? 8'h04 :
             slave_fault ? 8'h02 : slave_error ? 8'h03 : 8'h00;
        return {he, ns, ro, op};
    endfunction
    // Each completed read is compared with the oldest note.
    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest) begin
            ew = host_u.exp_q.pop_front();
            `CHK(avs_readdata, ew)
        end
    end
    always @(posedge host_tmo) begin
        n_fail++;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude;
    end
    initial begin
        r = $urandom(32'hEE12);
        {init_done, cfg_loaded, net_connected, role_primary, partner_present,
         net_error, slave_fault, slave_error} = 8'hE0;
        {ring_ok, time_sync_ok, net_mgmt_ok, file_fetch_fail, upgrade_refused,
         web_page_missing, event_log_disrupted} = 7'h70;
        node_diag_waiting = '0;
        node_configured = '0;
        module_net_address = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(`FMSC_OFF_CTRL, 32'h0);
        rd(`FMSC_OFF_ETH, 32'hFB);
        // Every request combination, with random module conditions.
        for (k = 0; k < 16; k++) begin
            r = $urandom;
            @(posedge clk);
            {init_done, cfg_loaded, net_connected, role_primary,
             partner_present, net_error, slave_fault, slave_error} <=
                r[7:0] | (k > 1 ? 8'hC0 : 8'h00);
            wr(`FMSC_OFF_CTRL, {28'h0, k[3:0]});
            settle;
            e = w0(k[3:0]);
            rd(`FMSC_OFF_STATE, e);
            `CHK(network_state_code, e[23:16])
            `CHK(hot_standby_active, k[3])
        end
        // Service health bits, read-only against writes.
        for (k = 0; k < 8; k++) begin
            r = $urandom;
            @(posedge clk);
            {ring_ok, time_sync_ok, net_mgmt_ok, file_fetch_fail,
             upgrade_refused, web_page_missing, event_log_disrupted} <= r[6:0];
            settle;
            wr(`FMSC_OFF_ETH, 32'h0);
            rd(`FMSC_OFF_ETH, {24'h0, ~r[0], ~r[1], ~r[2], ~r[3], r[4],
                1'b0, r[5], r[6]});
        end
        // Diagnostics vector and network address.
        @(posedge clk);
        dv = {$urandom, $urandom, $urandom, $urandom};
        dv[127] = 1'b0;
        node_diag_waiting <= dv[126:0];
        module_net_address <= dv[31:0];
        settle;
        for (k = 0; k < 4; k++) rd(`FMSC_OFF_DIAG0 + k, dv[32*k +: 32]);
        rd(`FMSC_OFF_ADDR, dv[31:0]);
        // Node enables gated by the configured nodes.
        ev = {$urandom, $urandom, $urandom, $urandom};
        cv = {$urandom, $urandom, $urandom, $urandom};
        @(posedge clk);
        node_configured <= cv[126:0];
        for (k = 0; k < 4; k++) wr(`FMSC_OFF_ENA0 + k, ev[32*k +: 32]);
        settle;
        `CHK(node_exchange_permit, ev[126:0] & cv[126:0])
        rd(`FMSC_OFF_ENA0 + 6'h03, {1'b0, ev[126:96]});
        // Interrupt raised, masked, enabled and cleared.
        @(posedge clk);
        node_diag_waiting <= '0;
        settle;
        wr(`FMSC_OFF_IRQ_STAT, 32'hF);
        rd(`FMSC_OFF_IRQ_STAT, 32'h0);
        @(posedge clk);
        node_diag_waiting <= 127'h20;
        settle;
        rd(`FMSC_OFF_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        wr(`FMSC_OFF_IRQ_MASK, 32'h1);
        settle;
        `CHK(irq, 1'b1)
        wr(`FMSC_OFF_IRQ_STAT, 32'h1);
        settle;
        `CHK(irq, 1'b0)
        // Unmapped word ignores writes and reads zero.
        wr(6'h3F, 32'hFFFFFFFF);
        rd(6'h3F, 32'h0);
        settle;
        conclude;
    end
endmodule // tb_fieldbus_master_status_control
